/* design/pulse_pkg.sv */
// Purpose: Shared constants of the energy pulse output stage.
// Assumes: One 25 MHz clock; filtered power arrives as a 24-bit magnitude.
// Notes:   Times are held in their own units, cycle counts derive from them.

package pulse_pkg;

    // ------------------------------------------------------------------
    // Clock and timing
    // ------------------------------------------------------------------
    localparam int unsigned CLOCK_HZ = 25000000;
    localparam int unsigned LOW_PULSE_MS = 275;
    localparam int unsigned CF_PULSE_MS = 90;
    localparam int unsigned HF_PULSE_US = 18;
    localparam int unsigned LOW_PULSE_CYCLES = LOW_PULSE_MS * (CLOCK_HZ / 1000);
    localparam int unsigned CF_PULSE_CYCLES = CF_PULSE_MS * (CLOCK_HZ / 1000);
    localparam int unsigned HF_PULSE_CYCLES = HF_PULSE_US * (CLOCK_HZ / 1000000);

    // ------------------------------------------------------------------
    // Datapath widths
    // ------------------------------------------------------------------
    localparam int POWER_W = 24;
    localparam int ACC_W = 40;
    localparam int SUM_W = ACC_W + 1;
    localparam int MULT_W = 12;
    localparam int CNT_W = 24;

    // ------------------------------------------------------------------
    // Scaling
    // ------------------------------------------------------------------
    // Full-scale DC product: 0.4 of the input range gives 0.4 x base rate
    localparam logic [POWER_W-1:0] POWER_FS = 24'h666666;
    // Creep floor: 0.0014 % of the full input range, rounded
    localparam logic [POWER_W-1:0] CREEP_POWER = 24'h0000EB;
    // Base-rate divider exponent for rate code 00, plus input width
    localparam logic [6:0] LOW_EXP_BASE = 7'h2D;
    localparam logic [5:0] CF_EXP_SCALE_HI = 6'h26;
    localparam logic [5:0] CF_EXP_SCALE_LO = 6'h27;
    localparam logic [5:0] CF_EXP_HF = 6'h1F;
    localparam logic [3:0] MULT_EXP_SCALE_HI = 4'h7;
    localparam logic [3:0] MULT_EXP_SCALE_LO = 4'h6;
    localparam logic [3:0] MULT_EXP_HF = 4'hB;
    localparam logic [1:0] RATE_HF = 2'h3;

    // ------------------------------------------------------------------
    // Reset values
    // ------------------------------------------------------------------
    localparam logic [1:0] CFG_RATE_RESET = 2'h0;
    localparam logic CFG_SCALE_RESET = 1'b0;

endpackage

/* design/pulse_if.sv */
// Purpose: Event-to-pulse link between the converter and a pulse shaper.
// Assumes: Both ends share one clock.
// Notes:   One instance per output.

`timescale 1ns/1ns

interface pulse_if;
    logic fire;
    logic fixed;
    logic active;

    modport ctrl (
        output fire,
        output fixed,
        input active
    );

    modport shaper (
        input fire,
        input fixed,
        output active
    );
endinterface

/* design/pin_sync.sv */
// Purpose: Two-flop synchroniser for static configuration pins.
// Assumes: Pins change rarely and independently.
// Notes:   First stage feeds only the second.

`timescale 1ns/1ns

module pin_sync #(
    parameter int WIDTH = 1
) (
    // Clock and reset
    input wire logic clock,
    input wire logic rst_n,
    // Pins in, synchronised levels out
    input wire logic [WIDTH-1:0] din,
    output logic [WIDTH-1:0] dout
);

    logic [WIDTH-1:0] stage1;

    always_ff @(posedge clock) begin
        if (!rst_n) begin
            stage1 <= '0;
            dout <= '0;
        end else begin
            stage1 <= din;
            dout <= stage1;
        end
    end

endmodule

/* design/pulse_shaper.sv */
// Purpose: Stretches a one-cycle event into an output pulse.
// Assumes: Events are at least two cycles apart.
// Notes:   Width is min(nominal, half the last period), or fixed.

`timescale 1ns/1ns

module pulse_shaper #(
    parameter int unsigned NOMINAL_CYCLES = pulse_pkg::CF_PULSE_CYCLES
) (
    // Clock and reset
    input wire logic clock,
    input wire logic rst_n,
    // Event in, pulse out
    pulse_if.shaper port
);

    localparam int CW = pulse_pkg::CNT_W;

    logic [CW-1:0] period_cnt;
    logic [CW-1:0] remain;
    logic [CW-1:0] high_len;
    logic [CW-1:0] width_latch;
    logic fixed_latch;

    // ------------------------------------------------------------------
    // Width selection
    // ------------------------------------------------------------------
    // Until a period is known the counter sits saturated, giving nominal
    wire logic [CW-1:0] nominal = CW'(NOMINAL_CYCLES);
    wire logic [CW-1:0] half_period = period_cnt >> 1;
    wire logic [CW-1:0] fit_width = (half_period < nominal) ? half_period : nominal;
    wire logic [CW-1:0] safe_width = (fit_width == '0) ? CW'(1) : fit_width;
    wire logic [CW-1:0] fixed_width = CW'(pulse_pkg::HF_PULSE_CYCLES);
    wire logic [CW-1:0] width = port.fixed ? fixed_width : safe_width;
    wire logic period_full = &period_cnt;

    // ------------------------------------------------------------------
    // Period and pulse counters
    // ------------------------------------------------------------------
    always_ff @(posedge clock) begin
        if (!rst_n) begin
            period_cnt <= '1;
            remain <= '0;
            port.active <= 1'b0;
        end else begin
            if (port.fire) begin
                period_cnt <= CW'(1);
            end else if (!period_full) begin
                period_cnt <= period_cnt + 1'b1;
            end
            // Width is latched at the event, so config changes never cut a pulse
            if (port.fire) begin
                remain <= width;
            end else if (remain != '0) begin
                remain <= remain - 1'b1;
            end
            port.active <= port.fire || (remain > CW'(1));
        end
    end

    // ------------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------------
    always_ff @(posedge clock) begin
        if (!rst_n) begin
            high_len <= '0;
            width_latch <= '0;
            fixed_latch <= 1'b0;
        end else begin
            if (port.fire) begin
                high_len <= '0;
                width_latch <= width;
                fixed_latch <= port.fixed;
            end else if (port.active) begin
                high_len <= high_len + 1'b1;
            end
        end
    end

    fixed_width_a: assert property (@(posedge clock) disable iff (!rst_n)
        $fell(port.active) && fixed_latch |-> high_len == fixed_width)
        else $error("fixed pulse width wrong");

    width_cap_a: assert property (@(posedge clock) disable iff (!rst_n)
        $fell(port.active) && !fixed_latch |-> high_len == width_latch
            && width_latch <= nominal)
        else $error("pulse width above limit");

endmodule

/* design/energy_pulse_output_gen.sv */
// Purpose: Digital-to-frequency pulse output stage of an energy meter.
// Assumes: power_in is the filtered product magnitude, valid every clock.
// Notes:   Calibration events are divided down to the two low-rate outputs.

`timescale 1ns/1ns

module energy_pulse_output_gen #(
    parameter int unsigned LOW_PULSE_CYCLES = pulse_pkg::LOW_PULSE_CYCLES,
    parameter int unsigned CF_PULSE_CYCLES = pulse_pkg::CF_PULSE_CYCLES
) (
    // Clock and reset
    input wire logic clock,
    input wire logic rst_n,

    // Filtered active power
    input wire logic [pulse_pkg::POWER_W-1:0] power_in,

    // Configuration pins
    input wire logic rate_sel_lsb,
    input wire logic rate_sel_msb,
    input wire logic calib_scale_sel,

    // Pulse outputs
    output logic low_rate_pulse_a,
    output logic low_rate_pulse_b,
    output logic calib_pulse_out
);

    localparam int ACC_W = pulse_pkg::ACC_W;
    localparam int SUM_W = pulse_pkg::SUM_W;
    localparam int MULT_W = pulse_pkg::MULT_W;

    // ------------------------------------------------------------------
    // Pin synchronisers
    // ------------------------------------------------------------------
    logic [2:0] pins_sync;

    wire logic [2:0] pins_raw = {calib_scale_sel, rate_sel_msb, rate_sel_lsb};

    pin_sync #(
        .WIDTH(3)
    ) u_pins (
        .clock(clock),
        .rst_n(rst_n),
        .din(pins_raw),
        .dout(pins_sync)
    );

    // ------------------------------------------------------------------
    // Active configuration
    // ------------------------------------------------------------------
    logic [1:0] cfg_rate;
    logic cfg_scale;
    logic [MULT_W-1:0] div_cnt;

    pulse_if cf_if ();
    pulse_if low_a_if ();
    pulse_if low_b_if ();

    // Taken only at a period boundary with no calibration pulse running
    wire logic cfg_apply = (div_cnt == '0) && !cf_if.active;
    wire logic cfg_differs = pins_sync != {cfg_scale, cfg_rate};
    wire logic cfg_change = cfg_apply && cfg_differs;

    always_ff @(posedge clock) begin
        if (!rst_n) begin
            cfg_rate <= pulse_pkg::CFG_RATE_RESET;
            cfg_scale <= pulse_pkg::CFG_SCALE_RESET;
        end else if (cfg_apply) begin
            cfg_rate <= pins_sync[1:0];
            cfg_scale <= pins_sync[2];
        end
    end

    // ------------------------------------------------------------------
    // Mode decode
    // ------------------------------------------------------------------
    wire logic hf_mode = !cfg_scale && (cfg_rate == pulse_pkg::RATE_HF);

    // Calibration threshold exponent per scale setting
    wire logic [5:0] exp_scaled = cfg_scale ? pulse_pkg::CF_EXP_SCALE_HI
                                            : pulse_pkg::CF_EXP_SCALE_LO;
    wire logic [5:0] cf_exp = hf_mode ? pulse_pkg::CF_EXP_HF : exp_scaled;

    // Lower base rate gets the larger multiple
    wire logic [3:0] mult_top = cfg_scale ? pulse_pkg::MULT_EXP_SCALE_HI
                                          : pulse_pkg::MULT_EXP_SCALE_LO;
    wire logic [3:0] mult_rated = mult_top - {2'h0, cfg_rate};
    wire logic [3:0] mult_exp = hf_mode ? pulse_pkg::MULT_EXP_HF : mult_rated;

    wire logic [MULT_W-1:0] calib_mult = MULT_W'(1) << mult_exp;
    wire logic [MULT_W-1:0] mult_last = calib_mult - 1'b1;
    wire logic [MULT_W-1:0] mult_mid = (calib_mult >> 1) - 1'b1;

    wire logic [ACC_W-1:0] cf_threshold = ACC_W'(1) << cf_exp;

    // ------------------------------------------------------------------
    // Creep gate
    // ------------------------------------------------------------------
    // Gating the addend rather than the pulses keeps both outputs in step
    wire logic above_creep = power_in >= pulse_pkg::CREEP_POWER;
    wire logic creep_ok = hf_mode || above_creep;
    wire logic [pulse_pkg::POWER_W-1:0] addend = creep_ok ? power_in : '0;

    // ------------------------------------------------------------------
    // Power accumulator
    // ------------------------------------------------------------------
    logic [ACC_W-1:0] acc;
    logic calib_event;

    // Rate is power x clock / 2^exp: linear in power and in base rate
    wire logic [SUM_W-1:0] sum = {1'b0, acc} + SUM_W'(addend);
    wire logic [SUM_W-1:0] thr_wide = SUM_W'(cf_threshold);
    wire logic crossed = sum >= thr_wide;
    wire logic [SUM_W-1:0] sum_left = sum - thr_wide;
    wire logic [ACC_W-1:0] acc_kept = crossed ? ACC_W'(sum_left) : ACC_W'(sum);
    // A new scale restarts the residue so a lower threshold cannot burst
    wire logic [ACC_W-1:0] next_acc = cfg_change ? '0 : acc_kept;

    always_ff @(posedge clock) begin
        if (!rst_n) begin
            acc <= '0;
            calib_event <= 1'b0;
        end else begin
            acc <= next_acc;
            calib_event <= crossed && !cfg_change;
        end
    end

    // ------------------------------------------------------------------
    // Low-rate divider
    // ------------------------------------------------------------------
    logic low_event_a;
    logic low_event_b;

    wire logic div_last = div_cnt >= mult_last;
    wire logic div_half = div_cnt == mult_mid;
    wire logic [MULT_W-1:0] div_step = div_last ? '0 : div_cnt + 1'b1;
    wire logic [MULT_W-1:0] next_div = calib_event ? div_step : div_cnt;

    always_ff @(posedge clock) begin
        if (!rst_n) begin
            div_cnt <= '0;
            low_event_a <= 1'b0;
            low_event_b <= 1'b0;
        end else begin
            div_cnt <= next_div;
            // Averaging over mult calibration events also halves AC maxima
            low_event_a <= calib_event && div_last;
            low_event_b <= calib_event && div_half && !div_last;
        end
    end

    // ------------------------------------------------------------------
    // Pulse shapers
    // ------------------------------------------------------------------
    assign cf_if.fire = calib_event;
    assign cf_if.fixed = hf_mode;
    assign low_a_if.fire = low_event_a;
    assign low_a_if.fixed = 1'b0;
    assign low_b_if.fire = low_event_b;
    assign low_b_if.fixed = 1'b0;

    pulse_shaper #(
        .NOMINAL_CYCLES(CF_PULSE_CYCLES)
    ) u_cf_shaper (
        .clock(clock),
        .rst_n(rst_n),
        .port(cf_if.shaper)
    );

    pulse_shaper #(
        .NOMINAL_CYCLES(LOW_PULSE_CYCLES)
    ) u_low_a_shaper (
        .clock(clock),
        .rst_n(rst_n),
        .port(low_a_if.shaper)
    );

    pulse_shaper #(
        .NOMINAL_CYCLES(LOW_PULSE_CYCLES)
    ) u_low_b_shaper (
        .clock(clock),
        .rst_n(rst_n),
        .port(low_b_if.shaper)
    );

    // ------------------------------------------------------------------
    // Output registers
    // ------------------------------------------------------------------
    always_ff @(posedge clock) begin
        if (!rst_n) begin
            low_rate_pulse_a <= 1'b1;
            low_rate_pulse_b <= 1'b1;
            calib_pulse_out <= 1'b0;
        end else begin
            low_rate_pulse_a <= !low_a_if.active;
            low_rate_pulse_b <= !low_b_if.active;
            calib_pulse_out <= cf_if.active;
        end
    end

    // ------------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------------
    creep_gate_a: assert property (@(posedge clock) disable iff (!rst_n)
        !hf_mode && !above_creep |=> !calib_event)
        else $error("pulse issued below creep floor");

    hf_mult_a: assert property (@(posedge clock) disable iff (!rst_n)
        hf_mode |-> calib_mult == 12'h800 && cf_if.fixed)
        else $error("high-frequency multiple wrong");

    scale_mult_a: assert property (@(posedge clock) disable iff (!rst_n)
        cfg_scale && cfg_rate == 2'h0 |-> calib_mult == 12'h080)
        else $error("scaled multiple wrong");

    rate_chain_a: assert property (@(posedge clock) disable iff (!rst_n)
        (7'(cf_exp) + 7'(mult_exp)) == (pulse_pkg::LOW_EXP_BASE - 7'(cfg_rate)))
        else $error("low-rate scaling inconsistent");

    outputs_alternate_a: assert property (@(posedge clock) disable iff (!rst_n)
        !(low_event_a && low_event_b))
        else $error("low-rate events coincide");

    half_split_a: assert property (@(posedge clock) disable iff (!rst_n)
        low_event_b |-> $past(calib_event) && $past(div_cnt) == $past(mult_mid))
        else $error("second output not at half period");

    divide_source_a: assert property (@(posedge clock) disable iff (!rst_n)
        low_event_a |-> $past(calib_event) && div_cnt == '0)
        else $error("low-rate event without calibration event");

    cfg_hold_a: assert property (@(posedge clock) disable iff (!rst_n)
        div_cnt != '0 |=> $stable(cfg_rate) && $stable(cfg_scale))
        else $error("configuration changed mid period");

    output_lag_a: assert property (@(posedge clock) disable iff (!rst_n)
        $rose(cf_if.active) |=> calib_pulse_out ##1 $past(calib_event, 3))
        else $error("calibration output not following event");

    // ------------------------------------------------------------------
    // Multiple, creep, residue, event spacing, configuration and polarity checks
    // ------------------------------------------------------------------
    scale_rates_a: assert property (@(posedge clock) disable iff (!rst_n)
        cfg_scale |-> calib_mult == (12'h080 >> cfg_rate))
        else $error("scaled multiple wrong for rate code");

    low_scale_a: assert property (@(posedge clock) disable iff (!rst_n)
        !cfg_scale && !hf_mode |-> calib_mult == (12'h040 >> cfg_rate))
        else $error("unscaled multiple wrong for rate code");

    div_range_a: assert property (@(posedge clock) disable iff (!rst_n)
        div_cnt <= mult_last)
        else $error("divider count beyond multiple");

    creep_hold_a: assert property (@(posedge clock) disable iff (!rst_n)
        !hf_mode && !above_creep && !cfg_change |=> $stable(acc))
        else $error("accumulator moved below creep floor");

    creep_off_a: assert property (@(posedge clock) disable iff (!rst_n)
        hf_mode |-> addend == power_in)
        else $error("creep floor active in high-frequency mode");

    residue_bound_a: assert property (@(posedge clock) disable iff (!rst_n)
        acc < cf_threshold)
        else $error("accumulator residue above threshold");

    event_spacing_a: assert property (@(posedge clock) disable iff (!rst_n)
        calib_event |=> !calib_event)
        else $error("calibration events back to back");

    cfg_clear_a: assert property (@(posedge clock) disable iff (!rst_n)
        cfg_change |=> acc == '0 && !calib_event)
        else $error("configuration change left residue");

    cfg_pulse_hold_a: assert property (@(posedge clock) disable iff (!rst_n)
        cf_if.active |=> $stable(cfg_rate) && $stable(cfg_scale))
        else $error("configuration changed under running pulse");

    low_a_polarity_a: assert property (@(posedge clock) disable iff (!rst_n)
        $rose(low_a_if.active) |=> !low_rate_pulse_a)
        else $error("first low-rate output not pulsing low");

    low_b_polarity_a: assert property (@(posedge clock) disable iff (!rst_n)
        $rose(low_b_if.active) |=> !low_rate_pulse_b)
        else $error("second low-rate output not pulsing low");

endmodule

/* tb/pulse_counter_model.sv */
// Purpose: Counter and pulse timer standing at the meter output pins.
// Assumes: Pins are sampled on the bench clock edge.
// Notes:   Reports each calibration pulse width when the pulse ends.

`timescale 1ns/1ns

module pulse_counter_model (
    // Clock and reset
    input wire logic clock,
    input wire logic rst_n,
    // Observed pins
    input wire logic low_a,
    input wire logic low_b,
    input wire logic calib,
    // Tallies
    output int rises,
    output int low_falls,
    output int both_low,
    output int width,
    output logic width_valid
);
    int run = 0;
    logic prev_a = 1'b1;
    logic prev_b = 1'b1;

    initial width = 0;
    initial width_valid = 1'b0;

    always @(posedge clock) begin
        width_valid <= 1'b0;
        if (!rst_n) begin
            rises <= 0;
            low_falls <= 0;
            both_low <= 0;
            run <= 0;
        end else begin
            prev_a <= low_a;
            prev_b <= low_b;
            if ((prev_a && !low_a) || (prev_b && !low_b))
                low_falls <= low_falls + 1;
            if (!low_a && !low_b)
                both_low <= both_low + 1;
            if (calib && run == 0)
                rises <= rises + 1;
            if (calib)
                run <= run + 1;
            else if (run != 0) begin
                width <= run;
                width_valid <= 1'b1;
                run <= 0;
            end
        end
    end
endmodule

/* tb/energy_pulse_output_gen_tb_top.sv */
// Purpose: Self-checking bench of the energy pulse output stage.
// Assumes: Calibration pulse nominal width shortened to 9000 cycles.
// Notes:   Low-rate pulses need far more cycles than the run allows.

`timescale 1ns/1ns

module energy_pulse_output_gen_tb_top;
    localparam int CF_CYC = 9000;
    logic clock = 1'b0;
    logic rst_n = 1'b0;
    logic [pulse_pkg::POWER_W-1:0] power_in = '0;
    logic rate_sel_lsb = 1'b0;
    logic rate_sel_msb = 1'b0;
    logic calib_scale_sel = 1'b0;
    logic low_rate_pulse_a;
    logic low_rate_pulse_b;
    logic calib_pulse_out;
    int rises;
    int low_falls;
    int both_low;
    int width;
    logic width_valid;
    int err_total = 0;
    int tests_run = 0;
    longint acc = 0;
    longint thr = 0;
    longint since = 0;
    int m_count = 0;
    bit m_first = 1'b1;
    bit hf = 1'b0;
    int wq[$];

    always #20 clock = ~clock;

    energy_pulse_output_gen #(.LOW_PULSE_CYCLES(40), .CF_PULSE_CYCLES(CF_CYC)) uut (
        .clock(clock),
        .rst_n(rst_n),
        .power_in(power_in),
        .rate_sel_lsb(rate_sel_lsb),
        .rate_sel_msb(rate_sel_msb),
        .calib_scale_sel(calib_scale_sel),
        .low_rate_pulse_a(low_rate_pulse_a),
        .low_rate_pulse_b(low_rate_pulse_b),
        .calib_pulse_out(calib_pulse_out)
    );

    pulse_counter_model far (
        .clock(clock),
        .rst_n(rst_n),
        .low_a(low_rate_pulse_a),
        .low_b(low_rate_pulse_b),
        .calib(calib_pulse_out),
        .rises(rises),
        .low_falls(low_falls),
        .both_low(both_low),
        .width(width),
        .width_valid(width_valid)
    );

    // ------------------------------------------------------------------
    // Reference accumulator
    // ------------------------------------------------------------------
    always @(posedge clock) begin
        if (!rst_n) begin
            acc = 0;
            since = 0;
            m_count = 0;
            m_first = 1'b1;
            wq.delete();
        end else begin
            since = since + 1;
            if (power_in >= pulse_pkg::CREEP_POWER || hf)
                acc = acc + power_in;
            if (acc >= thr) begin
                acc = acc - thr;
                m_count++;
                if (hf)
                    wq.push_back(pulse_pkg::HF_PULSE_CYCLES);
                else if (m_first)
                    wq.push_back(CF_CYC);
                else
                    wq.push_back(since / 2 < CF_CYC ? int'(since / 2) : CF_CYC);
                m_first = 1'b0;
                since = 0;
            end
        end
    end

    always @(posedge clock) begin
        if (width_valid) begin
            if (wq.size() == 0)
                check_count(0, 1);
            else
                check_count(wq.pop_front(), width);
        end
    end

    // ------------------------------------------------------------------
    // Checks and report
    // ------------------------------------------------------------------
    task automatic fail(string msg);
        err_total++;
        $display("[FAIL] %0t %s", $time, msg);
    endtask

    task automatic check_count(int exp, int got);
        tests_run++;
        if (got != exp)
            fail($sformatf("count %0d, expected %0d", got, exp));
    endtask

    task automatic check_level(logic got, logic exp);
        tests_run++;
        if (got !== exp)
            fail("output level wrong");
    endtask

    task automatic stop_test;
        if (err_total == 0 && tests_run > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask

    // ------------------------------------------------------------------
    // Stimulus
    // ------------------------------------------------------------------
    task automatic start(logic scale, logic msb, logic lsb);
        rst_n <= 1'b0;
        power_in <= '0;
        calib_scale_sel <= scale;
        rate_sel_msb <= msb;
        rate_sel_lsb <= lsb;
        hf = !scale && msb && lsb;
        thr = longint'(1) << (hf ? pulse_pkg::CF_EXP_HF :
            scale ? pulse_pkg::CF_EXP_SCALE_HI : pulse_pkg::CF_EXP_SCALE_LO);
        repeat (20) @(posedge clock);
        check_level(low_rate_pulse_a, 1'b1);
        check_level(low_rate_pulse_b, 1'b1);
        check_level(calib_pulse_out, 1'b0);
        rst_n <= 1'b1;
        repeat (10) @(posedge clock);
    endtask

    task automatic drive(logic [pulse_pkg::POWER_W-1:0] p, int n);
        power_in <= p;
        repeat (n) @(posedge clock);
    endtask

    // Pipeline is three edges deep, so let it drain before waiting
    task automatic settle;
        int n = 0;
        power_in <= '0;
        repeat (5) @(posedge clock);
        while (calib_pulse_out !== 1'b0 && n < 20000) begin
            n++;
            @(posedge clock);
        end
        if (n == 20000) begin
            fail("calibration pulse never ended");
            stop_test;
        end
        repeat (3) @(posedge clock);
        check_count(m_count, rises);
        check_count(0, low_falls);
        check_count(0, both_low);
        check_count(0, wq.size());
    endtask

    initial begin
        void'($urandom(32'h6AD3));
        // Accumulator left 16384 short of the threshold, then creep boundary
        start(1'b1, 1'b0, 1'b0);
        drive(24'hFFFFFF, 16384);
        check_count(0, rises);
        drive(24'h0000EA, 100);
        check_count(0, rises);
        drive(24'h0000EB, 100);
        drive(24'hFFFFFF, 25000);
        settle;
        check_count(2, rises);
        // High-frequency mode: creep floor off, fixed width
        start(1'b0, 1'b1, 1'b1);
        drive(24'hFFFFFF, 128);
        check_count(0, rises);
        drive(24'h000001, 200);
        check_count(1, rises);
        drive(24'h200000, 4100);
        settle;
        check_count(5, rises);
        // Scale low, rate 01, random heavy load
        start(1'b0, 1'b0, 1'b1);
        repeat (36000) begin
            power_in <= 24'hE00000 + 24'($urandom_range(0, 32'h1FFFFF));
            @(posedge clock);
        end
        settle;
        stop_test;
    end
endmodule
